/* core/rws_pkg.sv */
// Constants and types of the reset, wait and clock sequencer
package rws_pkg;
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  STAT_OFS       = 8'h04;
  localparam logic [7:0]  CNT_OFS        = 8'h08;
  localparam int          CTRL_GIE_BIT   = 0;
  localparam int          CTRL_TIE_BIT   = 1;
  localparam int          CTRL_PSI_BIT   = 2;
  localparam logic [2:0]  CTRL_RESET     = 3'h0;
  localparam int          STAT_STATE_LSB = 0;
  localparam int          STAT_MODE_LSB  = 2;
  localparam int          STAT_WDOG_BIT  = 4;
  localparam int          STAT_VEC_BIT   = 5;
  localparam int          RST_COUNT_CLKS = 2048;
  localparam int          MC_DIV         = 13;
  localparam int          MC_PC_PULSES   = 12;
  localparam int          TMR_DIV        = 12;
  localparam logic [2:0]  WDOG_LOW_CLKS  = 3'h4;
  localparam logic [11:0] VEC_LO_ADDR    = 12'hFFE;
  localparam logic [11:0] VEC_HI_ADDR    = 12'hFFF;
  localparam logic [2:0]  CYC_LONG       = 3'h5;
  localparam logic [2:0]  CYC_MID        = 3'h4;
  localparam logic [2:0]  CYC_SHORT      = 3'h2;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_COUNT = 2'b01,
    ST_RUN   = 2'b10,
    ST_WAIT  = 2'b11
  } rws_state_e;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_INT    = 2'b01,
    MODE_NMI    = 2'b10
  } rws_mode_e;

  typedef enum logic [2:0] {
    IT_BRANCH_BIT = 3'b000,
    IT_BRANCH     = 3'b001,
    IT_BIT        = 3'b010,
    IT_LOAD       = 3'b011,
    IT_ALU        = 3'b100,
    IT_COND       = 3'b101,
    IT_PROG       = 3'b110
  } rws_itype_e;
endpackage

/* core/rws_sequencer.sv */
// Reset, wait and clock sequencer of a small microcontroller core
`timescale 1ns/1ps
module rws_sequencer #(
  parameter int RST_COUNT = rws_pkg::RST_COUNT_CLKS
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  output logic             osc_enable,
  output logic             core_reset,
  output logic             fetch_enable,
  output logic             vector_fetch,
  output logic [11:0]      vector_addr,
  output logic [1:0]       core_mode,
  output logic             irq_service,
  output logic             nmi_service,
  output logic             wait_active,
  input  wire logic        wait_exec,
  input  wire logic        stop_exec,
  input  wire logic        return_from_interrupt_exec,
  input  wire logic        ext_irq,
  input  wire logic        nmi_irq,
  input  wire logic        timer_irq,
  input  wire logic        watchdog_expire,
  output logic             pc_step_en,
  output logic             mc_en,
  output logic             timer_clk_en,
  input  wire logic        instr_start,
  input  wire logic [2:0]  instr_type,
  output logic             instr_busy,
  output logic             instr_done
);
  localparam int CNT_W = $clog2(RST_COUNT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RST_COUNT - 1);
  localparam logic [3:0] MC_LAST = 4'(rws_pkg::MC_DIV - 1);
  localparam logic [3:0] PC_LAST = 4'(rws_pkg::MC_PC_PULSES - 1);
  localparam logic [3:0] TMR_LAST = 4'(rws_pkg::TMR_DIV - 1);

  initial begin
    if (RST_COUNT < 2) begin
      $error("RST_COUNT must be at least 2");
    end
  end

  logic                 pin_s1_reg;
  logic                 pin_s2_reg;
  logic [2:0]           ctrl_reg;
  rws_pkg::rws_state_e  state_reg;
  rws_pkg::rws_mode_e   mode_reg;
  rws_pkg::rws_mode_e   prev_mode_reg;
  logic [CNT_W-1:0]     cnt_reg;
  logic [2:0]           drv_cnt_reg;
  logic                 wdog_cause_reg;
  logic [1:0]           vec_cnt_reg;
  logic [3:0]           mc_cnt_reg;
  logic [3:0]           tmr_cnt_reg;
  logic [2:0]           instr_left_reg;

  logic gie;
  logic tim_wake;
  logic norm_req;
  logic nmi_take;
  logic norm_take;
  logic wake;
  logic idle_req;
  logic enter_reset;
  logic running;

  // Second flop alone feeds logic; the pin is asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg <= reset_pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign gie       = ctrl_reg[rws_pkg::CTRL_GIE_BIT];
  assign tim_wake  = timer_irq & ctrl_reg[rws_pkg::CTRL_TIE_BIT]
                   & ctrl_reg[rws_pkg::CTRL_PSI_BIT];
  assign norm_req  = ext_irq | tim_wake;
  assign nmi_take  = nmi_irq & (mode_reg != rws_pkg::MODE_NMI);
  assign norm_take = norm_req & gie & (mode_reg == rws_pkg::MODE_NORMAL);
  assign wake      = gie & (norm_req | nmi_irq);
  assign idle_req  = wait_exec | stop_exec;
  assign enter_reset = !pin_s2_reg | watchdog_expire;
  assign running   = (state_reg == rws_pkg::ST_RUN) && (vec_cnt_reg == 2'd0);

  // Watchdog drives the pin low for a few clocks, then hands it to the pull-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_cnt_reg   <= 3'h0;
      reset_pin_out <= 1'b0;
      reset_pin_oe  <= 1'b0;
    end else begin
      reset_pin_out <= 1'b0;
      if (watchdog_expire) begin
        drv_cnt_reg  <= rws_pkg::WDOG_LOW_CLKS;
        reset_pin_oe <= 1'b1;
      end else if (drv_cnt_reg != 3'h0) begin
        drv_cnt_reg  <= drv_cnt_reg - 3'h1;
        reset_pin_oe <= (drv_cnt_reg != 3'h1);
      end else begin
        reset_pin_oe <= 1'b0;
      end
    end
  end

  // Oscillator gated off while the pin reads low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_enable <= 1'b0;
    end else begin
      osc_enable <= pin_s2_reg;
    end
  end

  // Reset latch, post-release count, run and wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= rws_pkg::ST_RESET;
      cnt_reg        <= '0;
      wdog_cause_reg <= 1'b0;
      vec_cnt_reg    <= 2'd0;
    end else begin
      if (enter_reset || reset_pin_oe) begin
        state_reg <= rws_pkg::ST_RESET;
        cnt_reg   <= '0;
        if (watchdog_expire) begin
          wdog_cause_reg <= 1'b1;
        end else if (!pin_s2_reg && !reset_pin_oe
                     && (state_reg == rws_pkg::ST_RUN || state_reg == rws_pkg::ST_WAIT)) begin
          // Only a fresh press clears it; the echo of our own pull arrives in reset
          wdog_cause_reg <= 1'b0;
        end
      end else begin
        if (vec_cnt_reg != 2'd0) begin
          vec_cnt_reg <= vec_cnt_reg - 2'd1;
        end
        unique case (state_reg)
          rws_pkg::ST_RESET: begin
            state_reg <= rws_pkg::ST_COUNT;
            cnt_reg   <= '0;
          end
          rws_pkg::ST_COUNT: begin
            if (cnt_reg == CNT_LAST) begin
              state_reg   <= rws_pkg::ST_RUN;
              vec_cnt_reg <= 2'd2;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
          rws_pkg::ST_RUN: begin
            if (running && idle_req && !nmi_take && !norm_take) begin
              state_reg <= rws_pkg::ST_WAIT;
            end
          end
          rws_pkg::ST_WAIT: begin
            if (wake) begin
              state_reg <= rws_pkg::ST_RUN;
            end
          end
        endcase
      end
    end
  end

  // Core mode tracking and service requests
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg      <= rws_pkg::MODE_NMI;
      prev_mode_reg <= rws_pkg::MODE_NORMAL;
      irq_service   <= 1'b0;
      nmi_service   <= 1'b0;
    end else begin
      irq_service <= 1'b0;
      nmi_service <= 1'b0;
      if (state_reg == rws_pkg::ST_RESET || state_reg == rws_pkg::ST_COUNT) begin
        mode_reg      <= rws_pkg::MODE_NMI;
        prev_mode_reg <= rws_pkg::MODE_NORMAL;
      end else if (state_reg == rws_pkg::ST_WAIT) begin
        if (wake && !enter_reset) begin
          unique case (mode_reg)
            rws_pkg::MODE_NORMAL: begin
              if (nmi_irq) begin
                nmi_service   <= 1'b1;
                prev_mode_reg <= rws_pkg::MODE_NORMAL;
                mode_reg      <= rws_pkg::MODE_NMI;
              end else begin
                irq_service <= 1'b1;
                mode_reg    <= rws_pkg::MODE_INT;
              end
            end
            rws_pkg::MODE_INT: begin
              if (nmi_irq) begin
                nmi_service   <= 1'b1;
                prev_mode_reg <= rws_pkg::MODE_INT;
                mode_reg      <= rws_pkg::MODE_NMI;
              end
            end
            rws_pkg::MODE_NMI: begin
              mode_reg <= rws_pkg::MODE_NMI;
            end
            default: begin
              mode_reg <= rws_pkg::MODE_NMI;
            end
          endcase
        end
      end else if (running && !enter_reset) begin
        if (return_from_interrupt_exec) begin
          if (mode_reg == rws_pkg::MODE_NMI) begin
            mode_reg <= prev_mode_reg;
          end else begin
            mode_reg <= rws_pkg::MODE_NORMAL;
          end
        end else if (nmi_take) begin
          nmi_service   <= 1'b1;
          prev_mode_reg <= mode_reg;
          mode_reg      <= rws_pkg::MODE_NMI;
        end else if (norm_take) begin
          irq_service <= 1'b1;
          mode_reg    <= rws_pkg::MODE_INT;
        end
      end
    end
  end

  // Core-facing levels; fetch stops in wait while clocks keep running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_reset   <= 1'b1;
      fetch_enable <= 1'b0;
      wait_active  <= 1'b0;
      vector_fetch <= 1'b0;
      vector_addr  <= rws_pkg::VEC_LO_ADDR;
      core_mode    <= rws_pkg::MODE_NMI;
    end else begin
      core_reset   <= (state_reg == rws_pkg::ST_RESET) || (state_reg == rws_pkg::ST_COUNT);
      fetch_enable <= running;
      wait_active  <= (state_reg == rws_pkg::ST_WAIT);
      vector_fetch <= (vec_cnt_reg != 2'd0);
      vector_addr  <= (vec_cnt_reg == 2'd1) ? rws_pkg::VEC_HI_ADDR : rws_pkg::VEC_LO_ADDR;
      core_mode    <= mode_reg;
    end
  end

  // Dividers held at zero through reset so phases start aligned
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mc_cnt_reg   <= 4'h0;
      tmr_cnt_reg  <= 4'h0;
      mc_en        <= 1'b0;
      pc_step_en   <= 1'b0;
      timer_clk_en <= 1'b0;
    end else if (state_reg == rws_pkg::ST_RESET || state_reg == rws_pkg::ST_COUNT) begin
      mc_cnt_reg   <= 4'h0;
      tmr_cnt_reg  <= 4'h0;
      mc_en        <= 1'b0;
      pc_step_en   <= 1'b0;
      timer_clk_en <= 1'b0;
    end else begin
      mc_cnt_reg   <= (mc_cnt_reg == MC_LAST) ? 4'h0 : mc_cnt_reg + 4'h1;
      mc_en        <= (mc_cnt_reg == MC_LAST);
      pc_step_en   <= (mc_cnt_reg <= PC_LAST);
      tmr_cnt_reg  <= (tmr_cnt_reg == TMR_LAST) ? 4'h0 : tmr_cnt_reg + 4'h1;
      timer_clk_en <= (tmr_cnt_reg == TMR_LAST);
    end
  end

  function automatic logic [2:0] instr_cycles(input logic [2:0] kind);
    logic [2:0] n;
    n = rws_pkg::CYC_MID;
    if (kind == rws_pkg::IT_BRANCH_BIT) begin
      n = rws_pkg::CYC_LONG;
    end else if (kind == rws_pkg::IT_COND || kind == rws_pkg::IT_PROG) begin
      n = rws_pkg::CYC_SHORT;
    end
    return n;
  endfunction

  // Instruction length in machine cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_left_reg <= 3'h0;
      instr_busy     <= 1'b0;
      instr_done     <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      if (!running) begin
        instr_left_reg <= 3'h0;
        instr_busy     <= 1'b0;
      end else if (instr_left_reg == 3'h0) begin
        if (instr_start) begin
          instr_left_reg <= instr_cycles(instr_type);
          instr_busy     <= 1'b1;
        end
      end else if (mc_en) begin
        instr_left_reg <= instr_left_reg - 3'h1;
        if (instr_left_reg == 3'h1) begin
          instr_done <= 1'b1;
          instr_busy <= 1'b0;
        end
      end
    end
  end

  // APB slave: one wait state, unmapped addresses answer with an error
  logic acc;
  logic hit;
  assign acc = psel & penable & pready;
  assign hit = (paddr == rws_pkg::CTRL_OFS) || (paddr == rws_pkg::STAT_OFS)
             || (paddr == rws_pkg::CNT_OFS);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & !pready;
      pslverr <= psel & penable & !pready & !hit;
      prdata  <= 32'h00000000;
      if (psel && penable && !pready && !pwrite) begin
        if (paddr == rws_pkg::CTRL_OFS) begin
          prdata <= {29'h0, ctrl_reg};
        end else if (paddr == rws_pkg::STAT_OFS) begin
          prdata <= {26'h0, (vec_cnt_reg != 2'd0), wdog_cause_reg, mode_reg, state_reg};
        end else if (paddr == rws_pkg::CNT_OFS) begin
          prdata <= 32'(cnt_reg);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= rws_pkg::CTRL_RESET;
    end else if (acc && pwrite && paddr == rws_pkg::CTRL_OFS) begin
      ctrl_reg <= pwdata[2:0];
    end
  end
endmodule

/* verif/rws_sequencer_assertions.sv */
// Property checker for the reset, wait and clock sequencer
`timescale 1ns/1ps
module rws_sequencer_assertions #(
  parameter int RST_COUNT = rws_pkg::RST_COUNT_CLKS
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        reset_pin_in,
  input wire logic        reset_pin_oe,
  input wire logic        reset_pin_out,
  input wire logic        osc_enable,
  input wire logic        core_reset,
  input wire logic        fetch_enable,
  input wire logic        vector_fetch,
  input wire logic [11:0] vector_addr,
  input wire logic [1:0]  core_mode,
  input wire logic        wait_active,
  input wire logic        wait_exec,
  input wire logic        stop_exec,
  input wire logic        ext_irq,
  input wire logic        nmi_irq,
  input wire logic        timer_irq,
  input wire logic        watchdog_expire,
  input wire logic        pc_step_en,
  input wire logic        mc_en,
  input wire logic        timer_clk_en
);
  logic [12:0] hi_cnt;
  logic [4:0]  mc_gap;
  logic [4:0]  tm_gap;
  logic [4:0]  pc_cnt;
  logic        mc_ok;
  logic        tm_ok;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Reset cycles with the pin free; cleared by any new pull so a restart is seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hi_cnt <= '0;
    else if (!reset_pin_in || reset_pin_oe || !core_reset) hi_cnt <= '0;
    else if (hi_cnt != 13'h1FFF) hi_cnt <= hi_cnt + 13'h1;
  end
  // Divider gaps, judged only from the first pulse after reset
  always_ff @(posedge clk) begin
    if (!rst_n || core_reset) begin
      mc_gap <= '0;
      tm_gap <= '0;
      pc_cnt <= '0;
      mc_ok <= 1'h0;
      tm_ok <= 1'h0;
    end else begin
      mc_gap <= mc_en ? 5'h0 : mc_gap + 5'h1;
      pc_cnt <= mc_en ? 5'h0 : pc_cnt + {4'h0, pc_step_en};
      tm_gap <= timer_clk_en ? 5'h0 : tm_gap + 5'h1;
      mc_ok <= mc_ok | mc_en;
      tm_ok <= tm_ok | timer_clk_en;
    end
  end
  a_osc_off: assert property (!reset_pin_in [*4] |-> !osc_enable)
    else $error("oscillator on with pin low");
  a_osc_on: assert property (reset_pin_in [*4] |-> osc_enable)
    else $error("oscillator off with pin high");
  a_boot_nmi: assert property ($fell(core_reset) |-> core_mode == rws_pkg::MODE_NMI)
    else $error("restart not in nmi mode");
  a_count_len: assert property ($fell(core_reset) |-> hi_cnt >= RST_COUNT)
    else $error("reset left before full count");
  a_vector_order: assert property ($rose(vector_fetch) |-> vector_addr == rws_pkg::VEC_LO_ADDR
    ##1 vector_fetch && vector_addr == rws_pkg::VEC_HI_ADDR ##1 !vector_fetch)
    else $error("vector fetch order wrong");
  a_wait_entry: assert property ((wait_exec || stop_exec) && fetch_enable && !nmi_irq &&
    !ext_irq && !timer_irq && !watchdog_expire |-> ##2 wait_active && !fetch_enable)
    else $error("wait not entered");
  a_wait_refused: assert property (wait_exec && fetch_enable && nmi_irq &&
    core_mode != rws_pkg::MODE_NMI |-> ##2 !wait_active)
    else $error("wait entered with nmi pending");
  a_wait_nofetch: assert property (wait_active |-> !fetch_enable)
    else $error("fetch during wait");
  a_wake_prompt: assert property ($fell(wait_active) && !core_reset |-> fetch_enable)
    else $error("delay after wake");
  a_wdog_pull: assert property (watchdog_expire |-> ##[1:3] reset_pin_oe && !reset_pin_out)
    else $error("watchdog did not pull pin");
  a_wdog_len: assert property ($rose(reset_pin_oe) |-> reset_pin_oe [*4] ##1 !reset_pin_oe)
    else $error("pin pull length wrong");
  a_mc_period: assert property (mc_en && mc_ok |-> mc_gap == 5'hC && pc_cnt + pc_step_en == 12)
    else $error("machine cycle length wrong");
  a_tmr_period: assert property (timer_clk_en && tm_ok |-> tm_gap == 5'hB)
    else $error("timer clock period wrong");
endmodule
bind rws_sequencer rws_sequencer_assertions #(.RST_COUNT(RST_COUNT)) rws_sequencer_assertions_inst (
  .clk, .rst_n, .reset_pin_in, .reset_pin_oe, .reset_pin_out, .osc_enable, .core_reset,
  .fetch_enable, .vector_fetch, .vector_addr, .core_mode, .wait_active, .wait_exec, .stop_exec,
  .ext_irq, .nmi_irq, .timer_irq, .watchdog_expire, .pc_step_en, .mc_en, .timer_clk_en);

/* verif/rws_pin_model.sv */
// Reset pin with internal pull-up and an external push button
`timescale 1ns/1ps
module rws_pin_model (
  input  wire logic press_n,
  input  wire logic reset_pin_oe,
  input  wire logic reset_pin_out,
  output logic      reset_pin_in
);
  // Released pin floats to the pull-up, never holds its last level
  assign reset_pin_in = press_n & (reset_pin_oe ? reset_pin_out : 1'h1);
endmodule

/* verif/rws_sequencer_bench.sv */
// Self-checking bench of the reset, wait and clock sequencer
`timescale 1ns/1ps
module rws_sequencer_bench;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, press_n = 1'h1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, reset_pin_in, reset_pin_out, reset_pin_oe;
  logic        osc_enable, core_reset, fetch_enable, vector_fetch, irq_service;
  logic        nmi_service, wait_active, pc_step_en, mc_en, timer_clk_en, instr_busy, instr_done;
  logic [11:0] vector_addr;
  logic [1:0]  core_mode;
  logic        wait_exec = 1'h0, stop_exec = 1'h0, return_from_interrupt_exec = 1'h0, ext_irq = 1'h0;
  logic        nmi_irq = 1'h0, timer_irq = 1'h0, watchdog_expire = 1'h0, instr_start = 1'h0;
  logic [2:0]  instr_type = 3'h0;
  int          miscompares = 0, n_tests = 0, n_irq = 0, n_nmi = 0, n_mc = 0, s_mc, d_mc, i, t;
  int          len_tab [7] = '{rws_pkg::CYC_LONG, rws_pkg::CYC_MID, rws_pkg::CYC_MID,
    rws_pkg::CYC_MID, rws_pkg::CYC_MID, rws_pkg::CYC_SHORT, rws_pkg::CYC_SHORT};
  rws_sequencer #(.RST_COUNT(8)) rws_sequencer_inst (
    .clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .reset_pin_in, .reset_pin_out, .reset_pin_oe, .osc_enable, .core_reset, .fetch_enable,
    .vector_fetch, .vector_addr, .core_mode, .irq_service, .nmi_service, .wait_active,
    .wait_exec, .stop_exec, .return_from_interrupt_exec, .ext_irq, .nmi_irq, .timer_irq, .watchdog_expire,
    .pc_step_en, .mc_en, .timer_clk_en, .instr_start, .instr_type, .instr_busy, .instr_done);
  rws_pin_model rws_pin_model_inst (.press_n, .reset_pin_oe, .reset_pin_out, .reset_pin_in);
  always #20 clk = ~clk;
  // Pulse counters; non-blocking so readers at the edge see settled counts
  always @(posedge clk) begin
    if (irq_service) n_irq <= n_irq + 1;
    if (nmi_service) n_nmi <= n_nmi + 1;
    if (mc_en) n_mc <= n_mc + 1;
    if (instr_start) s_mc <= n_mc + int'(mc_en);
    if (instr_done) d_mc <= n_mc + int'(mc_en);
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    cyc(1);
    penable <= 1'h1;
    do cyc(1); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    cyc(1);
  endtask
  // Core strobes: 0 wait, 1 stop, 2 return, else watchdog
  task automatic pulse(input int k);
    case (k)
      0: wait_exec <= 1'h1;
      1: stop_exec <= 1'h1;
      2: return_from_interrupt_exec <= 1'h1;
      default: watchdog_expire <= 1'h1;
    endcase
    cyc(1);
    {wait_exec, stop_exec, return_from_interrupt_exec, watchdog_expire} <= 4'h0;
    cyc(3);
  endtask
  task automatic boot();
    for (i = 0; i < 100 && fetch_enable !== 1'h1; i++) cyc(1);
    chk(core_mode, rws_pkg::MODE_NMI);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    cyc(5000);
    miscompares++;
    results();
  end
  initial begin
    cyc(10);
    rst_n <= 1'h1;
    boot();
    apb(1'h0, 8'h0C, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'h1, rws_pkg::STAT_OFS, 32'hFF);
    apb(1'h0, rws_pkg::STAT_OFS, 32'h0);
    chk(rd[4:0], 5'h0A);
    $display("boot test done");
    apb(1'h1, rws_pkg::CTRL_OFS, 32'h1);
    pulse(0);
    chk(fetch_enable, 1'h0);
    ext_irq <= 1'h1;
    cyc(3);
    chk({wait_active, core_mode, n_irq[0]}, 4'h4);
    pulse(2);
    chk({n_irq[1:0], core_mode}, 4'h5);
    ext_irq <= 1'h0;
    pulse(0);
    nmi_irq <= 1'h1;
    cyc(1);
    nmi_irq <= 1'h0;
    cyc(3);
    chk({n_nmi[1:0], core_mode}, 4'h6);
    pulse(2);
    chk(core_mode, rws_pkg::MODE_INT);
    pulse(0);
    ext_irq <= 1'h1;
    cyc(3);
    chk({wait_active, n_irq[1:0], core_mode}, 5'h5);
    ext_irq <= 1'h0;
    pulse(2);
    chk(core_mode, rws_pkg::MODE_NORMAL);
    pulse(1);
    chk(wait_active, 1'h1);
    ext_irq <= 1'h1;
    cyc(3);
    chk({fetch_enable, n_irq[1:0]}, 3'h6);
    ext_irq <= 1'h0;
    pulse(2);
    $display("wake test done");
    apb(1'h1, rws_pkg::CTRL_OFS, 32'h6);
    pulse(0);
    {ext_irq, nmi_irq, timer_irq} <= 3'h7;
    cyc(20);
    chk(wait_active, 1'h1);
    {ext_irq, nmi_irq} <= 2'h0;
    apb(1'h1, rws_pkg::CTRL_OFS, 32'h7);
    cyc(3);
    chk(wait_active, 1'h0);
    timer_irq <= 1'h0;
    pulse(2);
    nmi_irq <= 1'h1;
    pulse(0);
    chk({wait_active, n_nmi[1:0]}, 3'h2);
    nmi_irq <= 1'h0;
    pulse(2);
    for (t = 0; t < 7; t++) begin
      for (i = 0; i < 20 && mc_en !== 1'h1; i++) cyc(1);
      instr_type <= t[2:0];
      instr_start <= 1'h1;
      cyc(1);
      instr_start <= 1'h0;
      for (i = 0; i < 100 && instr_done !== 1'h1; i++) cyc(1);
      cyc(1);
      chk(d_mc - s_mc, len_tab[t]);
      chk(instr_busy, 1'h0);
    end
    $display("instruction test done");
    pulse(0);
    pulse(3);
    chk({core_reset, reset_pin_in}, 2'h2);
    boot();
    apb(1'h0, rws_pkg::STAT_OFS, 32'h0);
    chk(rd[rws_pkg::STAT_WDOG_BIT], 1'h1);
    press_n <= 1'h0;
    cyc(4);
    chk(osc_enable, 1'h0);
    press_n <= 1'h1;
    cyc(4);
    chk(osc_enable, 1'h1);
    // Short second press lands inside the count
    press_n <= 1'h0;
    cyc(3);
    press_n <= 1'h1;
    boot();
    chk(core_reset, 1'h0);
    $display("reset test done");
    results();
  end
endmodule
